// ===== adcc_pkg.sv
// Operation
// - oversampling 256x, 128x, 64x by rate range
// - per-channel attenuator, 255 steps of 0.375 dB
// - stereo format uses six two-channel data lanes
// - tdm carries up to twelve channels, one lane
// - rate code 0b11 selects low delay filtering
// - four power levels per channel, twelve channels
// - global power 0b10/0b11 overrides, 0b00 per-channel
// - standalone or program mode sampled at power-up
// - default clock out buffered master, ports slave
// - clock out select: 10 buffered, 00/01 derived, 11 off
// - derived outputs land in 4-6 or 8-12 MHz
// - clock control writes only after power-up release
// - master ratio codes give 256/384/512/768 fs
// - rate field picks 48k, 96k, 192k ranges
// - core clock 512, 256, 128 times fs
// - pll enabled by reset without writes
// - direct mode: pll down, select bit set
// - pll reference code 0b01 locks to frame clock
// - bit clock generated internally in slave mode
package adcc_pkg;

  // register offsets
  localparam logic [7:0] OFS_PLL_CTRL0  = 8'h00;
  localparam logic [7:0] OFS_PLL_CTRL1  = 8'h01;
  localparam logic [7:0] OFS_CONV_CTRL0 = 8'h02;
  localparam logic [7:0] OFS_CONV_CTRL1 = 8'h03;
  localparam logic [7:0] OFS_BLOCK_PDN  = 8'h04;
  localparam logic [7:0] OFS_CH_POWER   = 8'h05;
  localparam logic [7:0] OFS_CH_ATTEN   = 8'h08;
  localparam logic [7:0] OFS_STATUS     = 8'h14;

  localparam int NUM_CH       = 12;
  localparam int NUM_LANES    = 6;
  localparam int NUM_PWR_REGS = 3;

  // field positions
  localparam int POS_PUP     = 0;
  localparam int POS_MCS     = 1;
  localparam int POS_PLLREF  = 6;
  localparam int POS_CLKSEL  = 3;
  localparam int POS_CLKOUT  = 4;
  localparam int POS_GLOBPWR = 6;
  localparam int POS_RATE    = 1;
  localparam int POS_BCLKGEN = 0;
  localparam int POS_MASTER  = 1;
  localparam int POS_TDM     = 2;
  localparam int POS_PLL_PDN = 1;

  // reset values
  localparam logic [7:0] RST_PLL_CTRL0  = 8'h00;
  localparam logic [7:0] RST_PLL_CTRL1  = 8'h20;
  localparam logic [7:0] RST_CONV_CTRL0 = 8'h00;
  localparam logic [7:0] RST_CONV_CTRL1 = 8'h00;
  localparam logic [7:0] RST_BLOCK_PDN  = 8'h00;
  localparam logic [7:0] RST_CH_POWER   = 8'h00;
  localparam logic [7:0] RST_CH_ATTEN   = 8'h00;

  localparam logic [1:0] CLKOUT_LOW  = 2'h0;
  localparam logic [1:0] CLKOUT_HIGH = 2'h1;
  localparam logic [1:0] CLKOUT_BUF  = 2'h2;
  localparam logic [1:0] CLKOUT_OFF  = 2'h3;
  localparam logic [1:0] PLLREF_FRAME = 2'h1;
  localparam logic [1:0] RATE_LOWDLY  = 2'h3;
  localparam logic [1:0] PWR_LOWER    = 2'h2;
  localparam logic [1:0] PWR_LOWEST   = 2'h3;

  localparam logic [9:0] OSR_48K  = 10'h100;
  localparam logic [9:0] CORE_48K = 10'h200;
  localparam int ATTEN_STEP_MDB = 375;
  localparam int BITS_PER_FRAME_LOG2 = 6;

  // pll settling time and its cycle count at 125 MHz
  localparam int CLK_MHZ          = 125;
  localparam int PLL_LOCK_TIME_US = 100;
  localparam int PLL_LOCK_CYCLES_DEF = PLL_LOCK_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {ADCC_OFF, ADCC_STANDALONE, ADCC_PROGRAM} adcc_mode_t;

endpackage

// ===== adcc_top.sv
`timescale 1ns/100ps
module adcc_top
  import adcc_pkg::*;
#(
  parameter int unsigned PLL_LOCK_CYCLES = PLL_LOCK_CYCLES_DEF
)
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  // device pins
  input  wire logic                 powerup_reset_pin,
  input  wire logic                 standalone_select,
  input  wire logic                 master_clock_input_pin,
  input  wire logic                 frame_clock_pin,
  input  wire logic                 bit_clock_pin,
  output logic                      clock_output_pin,
  // register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata,
  // clock and rate state
  output logic                      program_mode,
  output logic                      pll_enabled,
  output logic                      pll_ref_frame,
  output logic                      pll_locked,
  output logic                      core_direct,
  output logic                      audio_valid,
  output logic [9:0]                oversample_ratio,
  output logic [9:0]                core_clock_ratio,
  output logic [9:0]                master_ratio_eff,
  output logic                      low_delay,
  output logic                      active_bit_clock,
  // serial format and channels
  output logic [NUM_LANES-1:0]      data_lane_enable,
  output logic [3:0]                channels_per_lane,
  output logic [2*NUM_CH-1:0]       channel_power,
  output logic [8*NUM_CH-1:0]       channel_atten
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic logic [9:0] mcs_ratio(input logic [1:0] master_ratio_select);
    case (master_ratio_select)
      2'h0:    mcs_ratio = 10'd256;
      2'h1:    mcs_ratio = 10'd384;
      2'h2:    mcs_ratio = 10'd512;
      default: mcs_ratio = 10'd768;
    endcase
  endfunction

  function automatic logic [1:0] rate_shift(input logic [1:0] rate);
    rate_shift = (rate == 2'h0) ? 2'h0 : (rate == 2'h1) ? 2'h1 : 2'h2;
  endfunction

  // master clock divider for the derived clock outputs
  function automatic logic [2:0] clkout_div(input logic [1:0] sel, input logic [1:0] master_ratio_select);
    case ({sel[0], master_ratio_select})
      3'b000:  clkout_div = 3'd2;
      3'b001:  clkout_div = 3'd3;
      3'b010:  clkout_div = 3'd4;
      3'b011:  clkout_div = 3'd6;
      3'b100:  clkout_div = 3'd1;
      3'b101:  clkout_div = 3'd2;
      3'b110:  clkout_div = 3'd2;
      default: clkout_div = 3'd3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // power-up mode

  adcc_mode_t mode_reg;
  logic       pin_q_reg;
  logic       regs_live;
  logic       wr_en;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_reg  <= ADCC_OFF;
      pin_q_reg <= 1'b0;
    end
    else
    begin
      pin_q_reg <= powerup_reset_pin;
      if (!powerup_reset_pin)
        mode_reg <= ADCC_OFF;
      else if (!pin_q_reg)
        mode_reg <= standalone_select ? ADCC_STANDALONE : ADCC_PROGRAM;
    end
  end

  assign regs_live = powerup_reset_pin && (mode_reg != ADCC_OFF);
  assign wr_en     = reg_wr && powerup_reset_pin && (mode_reg == ADCC_PROGRAM);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] pll_ctrl0_reg;
  logic [7:0] pll_ctrl1_reg;
  logic [7:0] conv_ctrl0_reg;
  logic [7:0] conv_ctrl1_reg;
  logic [7:0] block_pdn_reg;
  logic [7:0] ch_power_reg [NUM_PWR_REGS];
  logic [7:0] ch_atten_reg [NUM_CH];
  logic [7:0] status_next;
  logic [7:0] rdata_next;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pll_ctrl0_reg  <= RST_PLL_CTRL0;
      pll_ctrl1_reg  <= RST_PLL_CTRL1;
      conv_ctrl0_reg <= RST_CONV_CTRL0;
      conv_ctrl1_reg <= RST_CONV_CTRL1;
      block_pdn_reg  <= RST_BLOCK_PDN;
      for (int i = 0; i < NUM_PWR_REGS; i++)
        ch_power_reg[i] <= RST_CH_POWER;
      for (int i = 0; i < NUM_CH; i++)
        ch_atten_reg[i] <= RST_CH_ATTEN;
    end
    else if (!regs_live)
    begin
      pll_ctrl0_reg  <= RST_PLL_CTRL0;
      pll_ctrl1_reg  <= RST_PLL_CTRL1;
      conv_ctrl0_reg <= RST_CONV_CTRL0;
      conv_ctrl1_reg <= RST_CONV_CTRL1;
      block_pdn_reg  <= RST_BLOCK_PDN;
      for (int i = 0; i < NUM_PWR_REGS; i++)
        ch_power_reg[i] <= RST_CH_POWER;
      for (int i = 0; i < NUM_CH; i++)
        ch_atten_reg[i] <= RST_CH_ATTEN;
    end
    else if (wr_en)
    begin
      case (reg_addr)
        OFS_PLL_CTRL0:  pll_ctrl0_reg  <= reg_wdata;
        OFS_PLL_CTRL1:  pll_ctrl1_reg  <= reg_wdata;
        OFS_CONV_CTRL0: conv_ctrl0_reg <= reg_wdata;
        OFS_CONV_CTRL1: conv_ctrl1_reg <= reg_wdata;
        OFS_BLOCK_PDN:  block_pdn_reg  <= reg_wdata;
        default:
        begin
          for (int i = 0; i < NUM_PWR_REGS; i++)
            if (reg_addr == OFS_CH_POWER + 8'(i))
              ch_power_reg[i] <= reg_wdata;
          for (int i = 0; i < NUM_CH; i++)
            if (reg_addr == OFS_CH_ATTEN + 8'(i))
              ch_atten_reg[i] <= reg_wdata;
        end
      endcase
    end
  end

  assign status_next = {2'h0, low_delay, audio_valid, pll_locked, core_direct,
                        pll_enabled, program_mode};

  always_comb
  begin
    rdata_next = 8'h00;
    case (reg_addr)
      OFS_PLL_CTRL0:  rdata_next = pll_ctrl0_reg;
      OFS_PLL_CTRL1:  rdata_next = pll_ctrl1_reg;
      OFS_CONV_CTRL0: rdata_next = conv_ctrl0_reg;
      OFS_CONV_CTRL1: rdata_next = conv_ctrl1_reg;
      OFS_BLOCK_PDN:  rdata_next = block_pdn_reg;
      OFS_STATUS:     rdata_next = status_next;
      default:
      begin
        for (int i = 0; i < NUM_PWR_REGS; i++)
          if (reg_addr == OFS_CH_POWER + 8'(i))
            rdata_next = ch_power_reg[i];
        for (int i = 0; i < NUM_CH; i++)
          if (reg_addr == OFS_CH_ATTEN + 8'(i))
            rdata_next = ch_atten_reg[i];
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // field aliases

  logic [1:0] master_ratio_select;
  logic [1:0] pll_ref;
  logic [1:0] clkout_req;
  logic [1:0] glob_pwr;
  logic [1:0] rate;
  logic       pup;
  logic       pll_pdn;
  logic       internal_bitclock_gen_en;

  assign pup        = pll_ctrl0_reg[POS_PUP];
  assign master_ratio_select        = pll_ctrl0_reg[POS_MCS +: 2];
  assign pll_ref    = pll_ctrl0_reg[POS_PLLREF +: 2];
  assign clkout_req = pll_ctrl1_reg[POS_CLKOUT +: 2];
  assign glob_pwr   = pll_ctrl1_reg[POS_GLOBPWR +: 2];
  assign rate       = conv_ctrl0_reg[POS_RATE +: 2];
  assign pll_pdn    = block_pdn_reg[POS_PLL_PDN];
  // slave port with internal generation requested
  assign internal_bitclock_gen_en = conv_ctrl1_reg[POS_BCLKGEN] && !conv_ctrl1_reg[POS_MASTER];

  ////////////////////////////////////////////////////////////////////////////
  // rate, ratio and channel settings

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      program_mode      <= 1'b0;
      pll_enabled       <= 1'b0;
      pll_ref_frame     <= 1'b0;
      core_direct       <= 1'b0;
      oversample_ratio  <= OSR_48K;
      core_clock_ratio  <= CORE_48K;
      master_ratio_eff  <= 10'd256;
      low_delay         <= 1'b0;
      data_lane_enable  <= '1;
      channels_per_lane <= 4'd2;
      channel_power     <= '0;
      channel_atten     <= '0;
    end
    else
    begin
      program_mode     <= (mode_reg == ADCC_PROGRAM);
      pll_enabled      <= regs_live && !pll_pdn;
      pll_ref_frame    <= (pll_ref == PLLREF_FRAME);
      core_direct      <= pll_pdn && pll_ctrl1_reg[POS_CLKSEL];
      oversample_ratio <= OSR_48K >> rate_shift(rate);
      core_clock_ratio <= CORE_48K >> rate_shift(rate);
      master_ratio_eff <= mcs_ratio(master_ratio_select) >> rate_shift(rate);
      low_delay        <= (rate == RATE_LOWDLY);
      if (conv_ctrl1_reg[POS_TDM])
      begin
        data_lane_enable  <= NUM_LANES'(1);
        channels_per_lane <= 4'(NUM_CH);
      end
      else
      begin
        data_lane_enable  <= '1;
        channels_per_lane <= 4'd2;
      end
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (glob_pwr == PWR_LOWER || glob_pwr == PWR_LOWEST)
          channel_power[2*i +: 2] <= glob_pwr;
        else
          channel_power[2*i +: 2] <= ch_power_reg[i/4][2*(i%4) +: 2];
        channel_atten[8*i +: 8] <= ch_atten_reg[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock output pin

  logic       mclk_q_reg;
  logic       mclk_rise;
  logic [1:0] clkout_sel_reg;
  logic [2:0] clkout_cnt_reg;
  logic [2:0] div_now;
  logic [2:0] cnt_next;

  assign mclk_rise = master_clock_input_pin && !mclk_q_reg;
  assign div_now   = clkout_div(clkout_sel_reg, master_ratio_select);
  assign cnt_next  = (clkout_cnt_reg + 3'd1 >= div_now) ? 3'd0 : clkout_cnt_reg + 3'd1;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mclk_q_reg       <= 1'b0;
      clkout_sel_reg   <= CLKOUT_BUF;
      clkout_cnt_reg   <= 3'd0;
      clock_output_pin <= 1'b0;
    end
    else
    begin
      mclk_q_reg <= master_clock_input_pin;
      // a new source is taken only while output and master are both low
      if (clkout_sel_reg != clkout_req && !clock_output_pin && !master_clock_input_pin)
      begin
        clkout_sel_reg <= clkout_req;
        clkout_cnt_reg <= 3'd0;
      end
      else
      begin
        case (clkout_sel_reg)
          CLKOUT_BUF: clock_output_pin <= master_clock_input_pin;
          CLKOUT_OFF: clock_output_pin <= 1'b0;
          CLKOUT_LOW, CLKOUT_HIGH:
          begin
            if (div_now == 3'd1)
              clock_output_pin <= master_clock_input_pin;
            else if (mclk_rise)
            begin
              clkout_cnt_reg   <= cnt_next;
              clock_output_pin <= (cnt_next < ((div_now + 3'd1) >> 1));
            end
          end
          default: clock_output_pin <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal bit clock, 64 bit periods per frame

  logic        frame_q_reg;
  logic        frame_rise;
  logic [15:0] frame_cnt_reg;
  logic [15:0] frame_period_reg;
  logic [9:0]  bit_cnt_reg;
  logic [9:0]  bit_half;
  logic        bit_gen_reg;

  assign frame_rise = frame_clock_pin && !frame_q_reg;
  assign bit_half   = (frame_period_reg[15:BITS_PER_FRAME_LOG2+1] == 9'd0) ? 10'd1 :
                      {1'b0, frame_period_reg[15:BITS_PER_FRAME_LOG2+1]};

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      frame_q_reg      <= 1'b0;
      frame_cnt_reg    <= 16'h0000;
      frame_period_reg <= 16'h0000;
      bit_cnt_reg      <= 10'h000;
      bit_gen_reg      <= 1'b0;
      active_bit_clock <= 1'b0;
    end
    else
    begin
      frame_q_reg <= frame_clock_pin;
      if (frame_rise)
      begin
        frame_period_reg <= frame_cnt_reg + 16'h0001;
        frame_cnt_reg    <= 16'h0000;
      end
      else if (frame_cnt_reg != 16'hffff)
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      // works from the frame alone, whichever pll reference is chosen
      if (!internal_bitclock_gen_en || frame_rise)
      begin
        bit_cnt_reg <= 10'h000;
        bit_gen_reg <= 1'b0;
      end
      else if (bit_cnt_reg + 10'h001 >= bit_half)
      begin
        bit_cnt_reg <= 10'h000;
        bit_gen_reg <= !bit_gen_reg;
      end
      else
        bit_cnt_reg <= bit_cnt_reg + 10'h001;
      active_bit_clock <= internal_bitclock_gen_en ? bit_gen_reg : bit_clock_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pll settling and audio valid

  logic [19:0] lock_cnt_reg;
  logic [3:0]  lock_cfg_reg;
  logic        ref_seen_reg;
  logic        ref_edge;
  logic        pll_run;

  assign ref_edge = (pll_ref == PLLREF_FRAME) ? frame_rise : mclk_rise;
  assign pll_run  = regs_live && pup && !pll_pdn;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lock_cnt_reg <= 20'h00000;
      lock_cfg_reg <= 4'h0;
      ref_seen_reg <= 1'b0;
      pll_locked   <= 1'b0;
      audio_valid  <= 1'b0;
    end
    else
    begin
      lock_cfg_reg <= {pll_ref, master_ratio_select};
      if (!pll_run || lock_cfg_reg != {pll_ref, master_ratio_select})
      begin
        lock_cnt_reg <= 20'h00000;
        ref_seen_reg <= 1'b0;
        pll_locked   <= 1'b0;
      end
      else
      begin
        if (ref_edge)
          ref_seen_reg <= 1'b1;
        if (ref_seen_reg && !pll_locked)
        begin
          if (lock_cnt_reg + 20'h00001 >= 20'(PLL_LOCK_CYCLES))
            pll_locked <= 1'b1;
          lock_cnt_reg <= lock_cnt_reg + 20'h00001;
        end
      end
      audio_valid <= regs_live && pup && (core_direct ? 1'b1 : pll_locked);
    end
  end

endmodule

// ===== adcc_props.sv
`timescale 1ns/100ps
module adcc_props
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 arst_n,
  // pins and register port
  input wire logic                 powerup_reset_pin,
  input wire logic                 standalone_select,
  input wire logic [7:0]           reg_addr,
  input wire logic                 reg_rd,
  input wire logic [7:0]           reg_rdata,
  // clock and format state
  input wire logic                 program_mode,
  input wire logic                 pll_locked,
  input wire logic                 core_direct,
  input wire logic                 audio_valid,
  input wire logic [9:0]           oversample_ratio,
  input wire logic [9:0]           core_clock_ratio,
  input wire logic [9:0]           master_ratio_eff,
  input wire logic                 low_delay,
  input wire logic [NUM_LANES-1:0] data_lane_enable,
  input wire logic [3:0]           channels_per_lane
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_osr_core_pair: assert property (core_clock_ratio == {oversample_ratio[8:0], 1'b0})
    else $error("oversampling ratio not half the core ratio");
  a_core_ratio_set: assert property (core_clock_ratio inside {10'h200, 10'h100, 10'h080})
    else $error("core clock ratio outside 512/256/128");
  a_low_delay_rate: assert property (low_delay |-> core_clock_ratio == 10'h080)
    else $error("low delay outside the highest rate range");
  a_eff_quarter: assert property (core_clock_ratio == 10'h080 |->
    master_ratio_eff inside {10'h040, 10'h060, 10'h080, 10'h0c0})
    else $error("effective master ratio not a quarter");
  a_stereo_lanes: assert property (channels_per_lane == 4'h2 |-> data_lane_enable == 6'h3f)
    else $error("stereo format without six lanes");
  a_tdm_one_lane: assert property (channels_per_lane == 4'hc |-> data_lane_enable == 6'h01)
    else $error("tdm format not on one lane");
  a_pin_low_off: assert property (!powerup_reset_pin |-> ##2 !program_mode)
    else $error("program mode while pin low");
  a_mode_program: assert property ($rose(powerup_reset_pin) && !standalone_select |->
    ##[1:3] program_mode)
    else $error("program mode not entered");
  a_valid_source: assert property (audio_valid |-> pll_locked || core_direct
    || $past(pll_locked) || $past(core_direct))
    else $error("audio valid without clock source");
  a_unmapped_zero: assert property (reg_rd && reg_addr > OFS_STATUS |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  c_low_delay: cover property (low_delay);
  c_tdm: cover property (channels_per_lane == 4'hc);
  c_locked: cover property (pll_locked && audio_valid);
  c_direct: cover property (core_direct && audio_valid);
endmodule

bind adcc_top adcc_props i_adcc_props (.core_clk, .arst_n, .powerup_reset_pin,
  .standalone_select, .reg_addr, .reg_rd, .reg_rdata, .program_mode, .pll_locked,
  .core_direct, .audio_valid, .oversample_ratio, .core_clock_ratio, .master_ratio_eff,
  .low_delay, .data_lane_enable, .channels_per_lane);

// ===== adcc_host_model.sv
`timescale 1ns/100ps
module adcc_host_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // which clocks the host supplies
  input wire logic mclk_en,
  input wire logic bclk_en,
  // clocks to the device
  output logic     master_clock_input_pin,
  output logic     frame_clock_pin,
  output logic     bit_clock_pin
);
  logic [8:0] phase_reg;

  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      phase_reg <= 9'h000;
    else
      phase_reg <= phase_reg + 9'h001;

  // one counter feeds all clocks so they stay coherent; unused clocks stand low
  assign master_clock_input_pin = mclk_en & phase_reg[1];
  assign bit_clock_pin          = bclk_en & phase_reg[2];
  assign frame_clock_pin        = phase_reg[8];
endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top import adcc_pkg::*;;
  logic core_clk = 1'b0, arst_n = 1'b0, powerup_reset_pin = 1'b0, standalone_select = 1'b0;
  logic mclk_en = 1'b1, bclk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic master_clock_input_pin, frame_clock_pin, bit_clock_pin, clock_output_pin;
  logic program_mode, pll_enabled, pll_ref_frame, pll_locked, core_direct, audio_valid;
  logic low_delay, active_bit_clock;
  logic [9:0] oversample_ratio, core_clock_ratio, master_ratio_eff;
  logic [NUM_LANES-1:0] data_lane_enable;
  logic [3:0] channels_per_lane;
  logic [2*NUM_CH-1:0] channel_power;
  logic [8*NUM_CH-1:0] channel_atten;
  int err_count = 0, n_checks = 0;

  always #4 core_clk = ~core_clk;

  adcc_host_model i_adcc_host_model (.core_clk, .arst_n, .mclk_en, .bclk_en,
    .master_clock_input_pin, .frame_clock_pin, .bit_clock_pin);
  adcc_top #(.PLL_LOCK_CYCLES(20)) i_adcc_top (.core_clk, .arst_n, .powerup_reset_pin,
    .standalone_select, .master_clock_input_pin, .frame_clock_pin, .bit_clock_pin,
    .clock_output_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .program_mode,
    .pll_enabled, .pll_ref_frame, .pll_locked, .core_direct, .audio_valid, .oversample_ratio,
    .core_clock_ratio, .master_ratio_eff, .low_delay, .active_bit_clock, .data_lane_enable,
    .channels_per_lane, .channel_power, .channel_atten);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic wait_lock();
    int n;
    for (n = 0; n < 5000 && pll_locked !== 1'b1; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk("pll_locked", 1, pll_locked);
    if (n == 5000)
      complete_run();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    logic [7:0] d;
    chk("osr", 256, oversample_ratio);
    chk("core", 512, core_clock_ratio);
    wr(OFS_PLL_CTRL1, 8'h30);
    @(posedge core_clk);
    powerup_reset_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("mode", 1, program_mode);
    chk("pll_en", 1, pll_enabled);
    rd(OFS_PLL_CTRL1, d);
    chk("ctrl1", RST_PLL_CTRL1, d);
    rd(8'h40, d);
    chk("unmapped", 0, d);
    $display("test powerup done");
  endtask

  task automatic t_rates();
    int r, m, s;
    logic [9:0] base;
    for (r = 0; r < 4; r++)
      for (m = 0; m < 4; m++)
      begin
        base = (m == 0) ? 10'd256 : (m == 1) ? 10'd384 : (m == 2) ? 10'd512 : 10'd768;
        s = (r > 2) ? 2 : r;
        wr(OFS_PLL_CTRL0, 8'(m << POS_MCS));
        wr(OFS_CONV_CTRL0, 8'(r << POS_RATE));
        settle();
        chk("ratio", base >> s, master_ratio_eff);
        chk("osr", 10'h100 >> s, oversample_ratio);
        chk("core", 10'h200 >> s, core_clock_ratio);
        chk("lowdly", r == 3, low_delay);
      end
    wr(OFS_CONV_CTRL0, 8'h00);
    $display("test rates done");
  endtask

  task automatic t_power();
    for (int i = 0; i < 3; i++)
      wr(OFS_CH_POWER + 8'(i), 8'he4);
    settle();
    chk("chpwr", 24'he4e4e4, channel_power);
    wr(OFS_PLL_CTRL1, 8'ha0);
    settle();
    chk("lower", 24'haaaaaa, channel_power);
    wr(OFS_PLL_CTRL1, 8'he0);
    settle();
    chk("lowest", 24'hffffff, channel_power);
    wr(OFS_PLL_CTRL1, 8'h20);
    wr(OFS_CH_ATTEN, 8'hff);
    wr(OFS_CH_ATTEN + 8'h0b, 8'h01);
    settle();
    chk("atten", 16'h01ff, {channel_atten[95:88], channel_atten[7:0]});
    $display("test power done");
  endtask

  task automatic t_format();
    logic pb;
    wr(OFS_CONV_CTRL1, 8'h04);
    settle();
    chk("tdm", {6'h01, 4'hc}, {data_lane_enable, channels_per_lane});
    wr(OFS_CONV_CTRL1, 8'h00);
    settle();
    chk("stereo", {6'h3f, 4'h2}, {data_lane_enable, channels_per_lane});
    repeat (4)
    begin
      pb = bit_clock_pin;
      @(posedge core_clk);
      #1;
      chk("ext_bclk", pb, active_bit_clock);
    end
    $display("test format done");
  endtask

  task automatic t_clkout();
    int sel_t[5] = '{2, 0, 1, 0, 3};
    int mcs_t[5] = '{0, 0, 3, 3, 0};
    int div_t[5] = '{1, 2, 3, 6, 0};
    int mr, orr, e;
    logic pm, po;
    for (int i = 0; i < 5; i++)
    begin
      wr(OFS_PLL_CTRL0, 8'(mcs_t[i] << POS_MCS));
      wr(OFS_PLL_CTRL1, 8'(sel_t[i] << POS_CLKOUT));
      repeat (32) @(posedge core_clk);
      #1;
      mr = 0;
      orr = 0;
      pm = master_clock_input_pin;
      po = clock_output_pin;
      repeat (512)
      begin
        @(posedge core_clk);
        #1;
        mr += int'(master_clock_input_pin && !pm);
        orr += int'(clock_output_pin && !po);
        pm = master_clock_input_pin;
        po = clock_output_pin;
      end
      e = (div_t[i] == 0) ? 0 : mr / div_t[i];
      chk("clkout_rate", 1, orr + 1 >= e && orr <= e + 1);
    end
    wr(OFS_PLL_CTRL1, 8'h20);
    $display("test clkout done");
  endtask

  task automatic t_pll();
    int t;
    logic pb;
    wr(OFS_PLL_CTRL0, 8'h01);
    wait_lock();
    settle();
    chk("valid", 1, audio_valid);
    @(posedge core_clk);
    mclk_en <= 1'b0;
    bclk_en <= 1'b0;
    wr(OFS_PLL_CTRL0, 8'h41);
    settle();
    chk("ref_frame", 1, pll_ref_frame);
    wait_lock();
    wr(OFS_CONV_CTRL1, 8'h01);
    repeat (1100) @(posedge core_clk);
    #1;
    t = 0;
    pb = active_bit_clock;
    repeat (512)
    begin
      @(posedge core_clk);
      #1;
      t += int'(active_bit_clock !== pb);
      pb = active_bit_clock;
    end
    chk("internal_bitclock_gen", 1, t >= 120 && t <= 136);
    wr(OFS_CONV_CTRL1, 8'h00);
    @(posedge core_clk);
    mclk_en <= 1'b1;
    wr(OFS_BLOCK_PDN, 8'h02);
    wr(OFS_PLL_CTRL1, 8'h28);
    wr(OFS_PLL_CTRL0, 8'h01);
    repeat (4) @(posedge core_clk);
    #1;
    chk("direct", 3'b101, {core_direct, pll_enabled, audio_valid});
    $display("test pll done");
  endtask

  task automatic t_standalone();
    @(posedge core_clk);
    powerup_reset_pin <= 1'b0;
    standalone_select <= 1'b1;
    repeat (2) @(posedge core_clk);
    powerup_reset_pin <= 1'b1;
    wr(OFS_CONV_CTRL0, 8'h06);
    settle();
    chk("standalone_select", 1'b0, program_mode);
    chk("sa_write", 1'b0, low_delay);
    $display("test standalone done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    settle();
    t_powerup();
    t_rates();
    t_power();
    t_format();
    t_clkout();
    t_pll();
    t_standalone();
    complete_run();
  end
endmodule
